// ### logic/serial_port_config_regs.sv
// serial control port slave with its configuration registers
// assumes the host clocks the port far slower than clk_sys_in (pins resynchronised)
//
// Functional notes
// - direction bit picks shared or separate read pin
// - bit order sets shift order and address step
// - soft reset restores every register default except its own bit, which stays set
// - soft reset bit held until host clears
// - readback select picks buffer or active copy
`timescale 1ns/100ps
`default_nettype none

module serial_port_config_regs (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe_out,
  output logic            serial_read_output_pin_out,
  output logic            serial_read_output_pin_oe_out,
  output logic [7:0]      port_setup_out,
  output logic [7:0]      powerdown_sync_active_out,
  output logic            soft_reset_out
);

  // ----------------------------------------------------------------
  // pin synchronisers: [0] meta, [1] synced, [2] previous (sclk only)
  // ----------------------------------------------------------------
  logic [2:0] sclk_s_r;
  logic [1:0] csn_s_r;
  logic [1:0] sdio_s_r;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_s_r <= 3'h0;
      csn_s_r  <= 2'h3;
      sdio_s_r <= 2'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], sclk_in};
      csn_s_r  <= {csn_s_r[0], cs_n_in};
      sdio_s_r <= {sdio_s_r[0], sdio_in};
    end
  end

  wire sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
  wire sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
  wire cs_active = ~csn_s_r[1];
  wire data_bit  = sdio_s_r[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  setup_r;
  logic [7:0]  setup_nxt;
  logic [7:0]  rb_sel_r;
  logic [7:0]  rb_sel_nxt;
  logic [7:0]  pd_buf_r;
  logic [7:0]  pd_buf_nxt;
  logic [7:0]  pd_act_r;
  logic [7:0]  pd_act_nxt;
  logic [7:0]  commit_r;
  logic [7:0]  commit_nxt;

  serial_port_config_pkg::port_state_type state_r;
  serial_port_config_pkg::port_state_type state_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [3:0]  bit_cnt_r;
  logic [3:0]  bit_cnt_nxt;
  logic [12:0] addr_r;
  logic [12:0] addr_nxt;
  logic        rd_r;
  logic        rd_nxt;
  logic [1:0]  len_r;
  logic [1:0]  len_nxt;
  logic [1:0]  left_r;
  logic [1:0]  left_nxt;
  logic [7:0]  tx_r;
  logic [7:0]  tx_nxt;
  logic        out_bit_r;
  logic        out_bit_nxt;

  wire lsb_first  = setup_r[serial_port_config_pkg::BIT_LSB_FIRST];
  wire soft_rst   = setup_r[serial_port_config_pkg::BIT_SOFT_RESET];
  wire sep_pin    = setup_r[serial_port_config_pkg::BIT_DIR_SELECT];
  wire read_act   = rb_sel_r[serial_port_config_pkg::BIT_READ_ACTIVE];
  wire commit_go  = commit_r[serial_port_config_pkg::BIT_COMMIT_ALL];

  // ----------------------------------------------------------------
  // shifting and framing
  // ----------------------------------------------------------------
  wire [15:0] shift_in  = lsb_first ? {data_bit, shift_r[15:1]}
                                    : {shift_r[14:0], data_bit};
  wire [7:0]  rx_byte   = lsb_first ? shift_in[15:8] : shift_in[7:0];
  wire        in_instr  = (state_r == serial_port_config_pkg::ST_INSTR);
  wire        in_data   = (state_r == serial_port_config_pkg::ST_DATA);
  wire        instr_end = sclk_rise & in_instr
                        & (bit_cnt_r == serial_port_config_pkg::INSTR_LAST_BIT);
  wire        byte_end  = sclk_rise & in_data
                        & (bit_cnt_r[2:0] == serial_port_config_pkg::BYTE_LAST_BIT);
  wire        last_byte = (len_r != serial_port_config_pkg::LEN_STREAMING)
                        & (left_r == 2'h0);
  wire [12:0] addr_step = lsb_first ? 13'(addr_r + 13'h1)
                                    : 13'(addr_r - 13'h1);
  wire        wr_fire   = byte_end & ~rd_r;
  wire [12:0] instr_addr = shift_in[serial_port_config_pkg::INSTR_ADDR_HI:0];

  // the read path byte follows the address that the next byte will use
  function automatic logic [7:0] read_mux(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      serial_port_config_pkg::ADDR_SERIAL_PORT_SETUP:   v = setup_r;
      serial_port_config_pkg::ADDR_READBACK_BANK_SEL:   v = rb_sel_r;
      serial_port_config_pkg::ADDR_POWERDOWN_SYNC_CTRL: v = read_act ? pd_act_r : pd_buf_r;
      serial_port_config_pkg::ADDR_SYSTEM_SPARE: v = serial_port_config_pkg::SPARE_READ_VALUE;
      serial_port_config_pkg::ADDR_COMMIT_BUFFERED:     v = commit_r;
      default:                                          v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    state_nxt   = state_r;
    shift_nxt   = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    addr_nxt    = addr_r;
    rd_nxt      = rd_r;
    len_nxt     = len_r;
    left_nxt    = left_r;
    tx_nxt      = tx_r;
    out_bit_nxt = out_bit_r;
    if (!cs_active) begin
      state_nxt   = serial_port_config_pkg::ST_IDLE;
      bit_cnt_nxt = 4'h0;
    end else begin
      unique case (state_r)
        serial_port_config_pkg::ST_IDLE: begin
          state_nxt   = serial_port_config_pkg::ST_INSTR;
          bit_cnt_nxt = 4'h0;
        end
        serial_port_config_pkg::ST_INSTR: begin
          if (sclk_rise) begin
            shift_nxt   = shift_in;
            bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
          end
          if (instr_end) begin
            state_nxt = serial_port_config_pkg::ST_DATA;
            rd_nxt    = shift_in[serial_port_config_pkg::INSTR_READ_BIT];
            len_nxt   = shift_in[serial_port_config_pkg::INSTR_LEN_HI:
                                 serial_port_config_pkg::INSTR_LEN_LO];
            left_nxt  = len_nxt;
            addr_nxt  = instr_addr;
            tx_nxt    = read_mux(instr_addr);
          end
        end
        serial_port_config_pkg::ST_DATA: begin
          if (sclk_rise) begin
            shift_nxt   = shift_in;
            bit_cnt_nxt = 4'(bit_cnt_r + 4'h1);
          end
          // read bits leave on the falling edge so the host samples on rising
          if (sclk_fall & rd_r) begin
            out_bit_nxt = lsb_first ? tx_r[0] : tx_r[7];
            tx_nxt      = lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
          end
          if (byte_end) begin
            addr_nxt = addr_step;
            left_nxt = 2'(left_r - 2'h1);
            tx_nxt   = read_mux(addr_step);
            if (last_byte) begin
              state_nxt = serial_port_config_pkg::ST_DONE;
            end
          end
        end
        serial_port_config_pkg::ST_DONE: begin
          state_nxt = serial_port_config_pkg::ST_DONE;
        end
        default: begin
          state_nxt = serial_port_config_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register bank updates
  // ----------------------------------------------------------------
  wire wr_setup  = wr_fire & (addr_r == serial_port_config_pkg::ADDR_SERIAL_PORT_SETUP);
  wire wr_rb_sel = wr_fire & (addr_r == serial_port_config_pkg::ADDR_READBACK_BANK_SEL);
  wire wr_pd     = wr_fire & (addr_r == serial_port_config_pkg::ADDR_POWERDOWN_SYNC_CTRL);
  wire wr_commit = wr_fire & (addr_r == serial_port_config_pkg::ADDR_COMMIT_BUFFERED);

  always_comb begin
    setup_nxt  = setup_r;
    rb_sel_nxt = rb_sel_r;
    pd_buf_nxt = pd_buf_r;
    pd_act_nxt = pd_act_r;
    commit_nxt = commit_r;
    // soft reset holds everything at default but keeps its own bit
    if (soft_rst) begin
      setup_nxt  = serial_port_config_pkg::RST_SERIAL_PORT_SETUP;
      setup_nxt[serial_port_config_pkg::BIT_SOFT_RESET] = 1'b1;
      rb_sel_nxt = serial_port_config_pkg::RST_READBACK_BANK_SEL;
      pd_buf_nxt = serial_port_config_pkg::RST_POWERDOWN_SYNC_CTRL;
      pd_act_nxt = serial_port_config_pkg::RST_POWERDOWN_SYNC_CTRL;
      commit_nxt = serial_port_config_pkg::RST_COMMIT_BUFFERED;
    end else begin
      if (commit_go) begin
        pd_act_nxt = pd_buf_r;
        commit_nxt = serial_port_config_pkg::RST_COMMIT_BUFFERED;
      end
      if (wr_rb_sel) begin
        rb_sel_nxt = rx_byte;
      end
      if (wr_pd) begin
        pd_buf_nxt = rx_byte;
      end
      // a fresh write wins over the self-clear in the same cycle
      if (wr_commit) begin
        commit_nxt = rx_byte & 8'h01;
      end
    end
    // only a host write or sys_rst_in can end a soft reset
    if (wr_setup) begin
      setup_nxt = rx_byte;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      setup_r  <= serial_port_config_pkg::RST_SERIAL_PORT_SETUP;
      rb_sel_r <= serial_port_config_pkg::RST_READBACK_BANK_SEL;
      pd_buf_r <= serial_port_config_pkg::RST_POWERDOWN_SYNC_CTRL;
      pd_act_r <= serial_port_config_pkg::RST_POWERDOWN_SYNC_CTRL;
      commit_r <= serial_port_config_pkg::RST_COMMIT_BUFFERED;
    end else begin
      setup_r  <= setup_nxt;
      rb_sel_r <= rb_sel_nxt;
      pd_buf_r <= pd_buf_nxt;
      pd_act_r <= pd_act_nxt;
      commit_r <= commit_nxt;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r   <= serial_port_config_pkg::ST_IDLE;
      shift_r   <= 16'h0000;
      bit_cnt_r <= 4'h0;
      addr_r    <= 13'h0000;
      rd_r      <= 1'b0;
      len_r     <= 2'h0;
      left_r    <= 2'h0;
      tx_r      <= 8'h00;
      out_bit_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      addr_r    <= addr_nxt;
      rd_r      <= rd_nxt;
      len_r     <= len_nxt;
      left_r    <= left_nxt;
      tx_r      <= tx_nxt;
      out_bit_r <= out_bit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers and status outputs
  // ----------------------------------------------------------------
  wire drive_nxt = cs_active & in_data & rd_r;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sdio_out                      <= 1'b0;
      sdio_oe_out                   <= 1'b0;
      serial_read_output_pin_out    <= 1'b0;
      serial_read_output_pin_oe_out <= 1'b0;
      port_setup_out                <= serial_port_config_pkg::RST_SERIAL_PORT_SETUP;
      powerdown_sync_active_out     <= serial_port_config_pkg::RST_POWERDOWN_SYNC_CTRL;
      soft_reset_out                <= 1'b0;
    end else begin
      sdio_out                      <= out_bit_nxt;
      sdio_oe_out                   <= drive_nxt & ~sep_pin;
      serial_read_output_pin_out    <= out_bit_nxt;
      serial_read_output_pin_oe_out <= drive_nxt & sep_pin;
      port_setup_out                <= setup_nxt;
      powerdown_sync_active_out     <= pd_act_nxt;
      soft_reset_out                <= setup_nxt[serial_port_config_pkg::BIT_SOFT_RESET];
    end
  end

endmodule // serial_port_config_regs
`default_nettype wire

// ### logic/serial_port_config_pkg.sv
// serial control port configuration constants: offsets, fields, defaults
// assumes a 16-bit instruction word (read flag, 2-bit length, 13-bit address)
`default_nettype none

package serial_port_config_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [12:0] ADDR_SERIAL_PORT_SETUP   = 13'h000;
  localparam logic [12:0] ADDR_READBACK_BANK_SEL   = 13'h004;
  localparam logic [12:0] ADDR_POWERDOWN_SYNC_CTRL = 13'h230;
  localparam logic [12:0] ADDR_SYSTEM_SPARE        = 13'h231;
  localparam logic [12:0] ADDR_COMMIT_BUFFERED     = 13'h232;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_DIR_SELECT   = 7;
  localparam int BIT_LSB_FIRST    = 6;
  localparam int BIT_SOFT_RESET   = 5;
  localparam int BIT_LONG_INSTR   = 4;
  localparam int BIT_READ_ACTIVE  = 0;
  localparam int BIT_COMMIT_ALL   = 0;
  localparam int INSTR_READ_BIT   = 15;
  localparam int INSTR_LEN_HI     = 14;
  localparam int INSTR_LEN_LO     = 13;
  localparam int INSTR_ADDR_HI    = 12;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SERIAL_PORT_SETUP   = 8'h18;
  localparam logic [7:0] RST_READBACK_BANK_SEL   = 8'h00;
  localparam logic [7:0] RST_POWERDOWN_SYNC_CTRL = 8'h00;
  localparam logic [7:0] RST_COMMIT_BUFFERED     = 8'h00;
  localparam logic [7:0] SPARE_READ_VALUE        = 8'h00;
  localparam logic [3:0] INSTR_LAST_BIT          = 4'hf;
  localparam logic [2:0] BYTE_LAST_BIT           = 3'h7;
  localparam logic [1:0] LEN_STREAMING           = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_DONE  = 4'b1000
  } port_state_type;

endpackage

`default_nettype wire

// ### testbench/serial_port_config_regs_asserts.sv
// checker: timing relations at the configuration register block's ports
// assumes binding onto serial_port_config_regs, one clock domain
`timescale 1ns/100ps
`default_nettype none
module serial_port_config_regs_asserts (
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  input wire logic       cs_n_in,
  input wire logic       sdio_oe_out,
  input wire logic       serial_read_output_pin_oe_out,
  input wire logic [7:0] port_setup_out,
  input wire logic [7:0] powerdown_sync_active_out,
  input wire logic       soft_reset_out
);
  // ------------------
  // properties
  // ------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  rst_defaults_a: assert property ($past(sys_rst_in) |-> port_setup_out == 8'h18
    && powerdown_sync_active_out == 8'h00 && !soft_reset_out) else $error("bad reset values");
  shared_pin_a: assert property (sdio_oe_out |-> !port_setup_out[7]
    && !serial_read_output_pin_oe_out) else $error("shared pin driven in separate mode");
  separate_pin_a: assert property (serial_read_output_pin_oe_out |-> port_setup_out[7]
    && !sdio_oe_out) else $error("separate pin driven in shared mode");
  oe_release_a: assert property (cs_n_in [*6] |-> !sdio_oe_out
    && !serial_read_output_pin_oe_out) else $error("pin still driven when deselected");
  soft_hold_a: assert property ((cs_n_in && soft_reset_out) [*8] |=> soft_reset_out)
    else $error("soft reset cleared itself");
  soft_default_a: assert property (soft_reset_out [*2] |->
    powerdown_sync_active_out == 8'h00) else $error("active copy not at default");
  active_quiet_a: assert property (cs_n_in [*8] |=>
    $stable(powerdown_sync_active_out)) else $error("active copy changed while idle");
  setup_quiet_a: assert property (cs_n_in [*8] |=> $stable(port_setup_out))
    else $error("setup changed while idle");
endmodule // serial_port_config_regs_asserts

bind serial_port_config_regs serial_port_config_regs_asserts serial_port_config_regs_asserts_inst (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n_in), .sdio_oe_out(sdio_oe_out),
  .serial_read_output_pin_oe_out(serial_read_output_pin_oe_out), .port_setup_out(port_setup_out),
  .powerdown_sync_active_out(powerdown_sync_active_out), .soft_reset_out(soft_reset_out));
`default_nettype wire

// ### testbench/serial_host_model.sv
// host controller model: 16-bit instruction transfers on the serial port
// assumes clk_sys_in at 50 ns; serial clock period is eight system clocks
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
  input  wire logic clk_sys_in,
  input  wire logic shared_data_in,
  input  wire logic shared_oe_in,
  input  wire logic sep_data_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdio_wire_out
);
  // ------------------
  // transfer engine
  // ------------------
  logic lsb_mode = 1'b0;
  logic sep_mode = 1'b0;
  logic drv      = 1'b0;
  initial sclk_out = 1'b0;
  initial cs_n_out = 1'b1;
  // device wins the shared line while it drives it
  assign sdio_wire_out = shared_oe_in ? shared_data_in : drv;
  task automatic half();
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] addr,
                      input logic [31:0] wd, output logic [31:0] rdat);
    logic [15:0] ins;
    int i;
    int j;
    if (!rd && addr == 13'h000) begin
      wd[4] = 1'b1;
      wd[3:0] = {wd[4], wd[5], wd[6], wd[7]};
    end
    ins = {rd, len, addr};
    rdat = 32'h0;
    cs_n_out = 1'b0;
    for (i = 0; i < 16 + 8 * (len + 1); i++) begin
      j = (i - 16) / 8 * 8 + (lsb_mode ? (i % 8) : 7 - (i % 8));
      if (i < 16) drv = lsb_mode ? ins[i] : ins[15 - i];
      else if (!rd) drv = wd[j];
      else drv = ~drv; // released line never holds the last bit
      half();
      if (rd && i >= 16) rdat[j] = sep_mode ? sep_data_in : sdio_wire_out;
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
    end
    half();
    cs_n_out = 1'b1;
    half();
    if (!rd && addr == 13'h000) begin
      lsb_mode = wd[6] & ~wd[5];
      sep_mode = wd[7] & ~wd[5];
    end
  endtask
endmodule // serial_host_model
`default_nettype wire

// ### testbench/serial_port_config_regs_tb_top.sv
// testbench: host model plus behavioural register model against the block
// assumes the checker is bound from its own file
`timescale 1ns/100ps
`default_nettype none
module serial_port_config_regs_tb_top;
  logic       clk_sys_in, sys_rst_in, sclk, cs_n, wire_d, sd, sd_oe, sep_d, sep_oe, sr;
  logic [7:0] setup, pd_act;
  logic [7:0] m_setup = 8'h18, m_rb = 8'h00, m_buf = 8'h00, m_act = 8'h00, seed = 8'h28;
  int         miscompares = 0, checks_done = 0;
  serial_port_config_regs serial_port_config_regs_inst (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .sclk_in(sclk), .cs_n_in(cs_n), .sdio_in(wire_d), .sdio_out(sd),
    .sdio_oe_out(sd_oe), .serial_read_output_pin_out(sep_d),
    .serial_read_output_pin_oe_out(sep_oe),
    .port_setup_out(setup), .powerdown_sync_active_out(pd_act), .soft_reset_out(sr));
  serial_host_model serial_host_model_inst (.clk_sys_in(clk_sys_in), .shared_data_in(sd),
    .shared_oe_in(sd_oe), .sep_data_in(sep_d), .sclk_out(sclk), .cs_n_out(cs_n),
    .sdio_wire_out(wire_d));
  // ------------------
  // model and tasks
  // ------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] mread(input logic [12:0] a);
    if (a == 13'h000) return m_setup;
    if (a == 13'h004) return m_rb;
    if (a == 13'h230) return m_rb[0] ? m_act : m_buf;
    return 8'h00;
  endfunction
  task automatic mwrite(input logic [12:0] a, input logic [7:0] d);
    if (m_setup[5] && a != 13'h000) return;
    case (a)
      13'h000: m_setup = d[5] ? 8'h38 : d;
      13'h004: m_rb = d;
      13'h230: m_buf = d;
      13'h232: if (d[0]) m_act = m_buf;
      default: ;
    endcase
    if (m_setup[5]) {m_rb, m_buf, m_act} = 24'h0;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] len, input logic [12:0] a, input logic [31:0] d);
    logic [31:0] r;
    int k;
    serial_host_model_inst.xfer(1'b0, len, a, d, r);
    for (k = 0; k <= len; k++) begin
      mwrite(a, d[8 * k +: 8]);
      a = m_setup[6] ? a + 13'h1 : a - 13'h1;
    end
    check(setup, m_setup);
    check(pd_act, m_act);
    check({7'h0, sr}, {7'h0, m_setup[5]});
  endtask
  task automatic rdc(input logic [12:0] a);
    logic [31:0] r;
    serial_host_model_inst.xfer(1'b1, 2'h0, a, 24'h0, r);
    check(r[7:0], mread(a));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ------------------
  // sequence
  // ------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    miscompares++;
    $display("unexpected at %0t: run too long", $time);
    final_report();
  end
  initial begin
    sys_rst_in = 1'b1;
    repeat (16) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    check(setup, 8'h18);
    check(pd_act, 8'h00);
    rdc(13'h000);
    rdc(13'h231);
    rdc(13'h100);
    $display("test reset done");
    seed = lfsr(seed);
    wr(2'h0, 13'h230, {16'h0, seed});
    rdc(13'h230);
    wr(2'h0, 13'h004, 24'h1);
    rdc(13'h230);
    wr(2'h0, 13'h232, 24'h1);
    rdc(13'h232);
    seed = lfsr(seed);
    wr(2'h2, 13'h232, {seed, 16'h0001});
    wr(2'h0, 13'h232, 24'h1);
    rdc(13'h230);
    seed = lfsr(seed);
    wr(2'h3, 13'h232, {8'h00, seed, 16'h0001});
    wr(2'h0, 13'h232, 24'h1);
    rdc(13'h230);
    $display("test buffered copy done");
    wr(2'h0, 13'h000, 24'h5a);
    seed = lfsr(seed);
    wr(2'h1, 13'h230, {16'h0, seed});
    wr(2'h0, 13'h232, 24'h1);
    rdc(13'h230);
    rdc(13'h000);
    wr(2'h0, 13'h000, 24'h99);
    rdc(13'h230);
    rdc(13'h004);
    wr(2'h0, 13'h000, 24'h18);
    $display("test bit order and pins done");
    wr(2'h0, 13'h000, 24'h3c);
    wr(2'h0, 13'h230, 24'h5);
    repeat (40) @(posedge clk_sys_in);
    check({7'h0, sr}, 8'h01);
    rdc(13'h230);
    wr(2'h0, 13'h000, 24'h18);
    rdc(13'h004);
    $display("test soft reset done");
    seed = lfsr(seed);
    wr(2'h0, 13'h230, {16'h0, seed});
    wr(2'h0, 13'h232, 24'h1);
    sys_rst_in = 1'b1;
    repeat (16) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    {m_rb, m_buf, m_act} = 24'h0;
    repeat (4) @(posedge clk_sys_in);
    check(setup, 8'h18);
    check(pd_act, 8'h00);
    rdc(13'h230);
    $display("test mid-run reset done");
    final_report();
  end
endmodule // serial_port_config_regs_tb_top
`default_nettype wire
